// >>> design/ccc_pkg.sv
package ccc_pkg;

    // ------------------------------------------------------------
    // Channel layout
    // ------------------------------------------------------------
    localparam int         CH_NUM      = 4;
    localparam logic [7:0] CH_STRIDE   = 8'h30;

    // ------------------------------------------------------------
    // Byte offsets of channel 1
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CFG     = 8'h32;
    localparam logic [7:0] OFF_GAIN_LO = 8'h33;
    localparam logic [7:0] OFF_GAIN_HI = 8'h34;
    localparam logic [7:0] OFF_CHOP_LO = 8'h35;
    localparam logic [7:0] OFF_CHOP_HI = 8'h36;
    localparam logic [7:0] OFF_DEC_B0  = 8'h37;
    localparam logic [7:0] OFF_DEC_B1  = 8'h38;
    localparam logic [7:0] OFF_DEC_B2  = 8'h39;
    localparam logic [7:0] OFF_SHIFT   = 8'h3A;
    localparam logic [7:0] OFF_FCTL    = 8'h3B;
    localparam logic [7:0] OFF_F1DMIN  = 8'h3C;
    localparam logic [7:0] OFF_F1DMAX  = 8'h3D;
    localparam logic [7:0] OFF_F1CMIN  = 8'h3E;
    localparam logic [7:0] OFF_F1CMAX  = 8'h3F;
    localparam logic [7:0] OFF_F2DMIN  = 8'h40;
    localparam logic [7:0] OFF_F2DMAX  = 8'h41;
    localparam logic [7:0] OFF_FIRST   = OFF_CFG;
    localparam logic [7:0] OFF_LAST    = OFF_F2DMAX;

    // ------------------------------------------------------------
    // Channel configuration byte
    // ------------------------------------------------------------
    localparam int         CFG_AAF     = 0;
    localparam int         CFG_INV     = 1;
    localparam int         CFG_CALPH   = 2;
    localparam int         CFG_CICBYP  = 4;
    localparam int         CFG_F0EN    = 5;
    localparam int         CFG_F1EN    = 6;
    localparam int         CFG_F0BYP   = 7;
    localparam logic [7:0] CFG_MASK    = 8'hF7;
    localparam logic [7:0] CFG_RST     = 8'hF0;

    // ------------------------------------------------------------
    // Filter 0 control byte
    // ------------------------------------------------------------
    localparam int         FCTL_F2EN   = 0;
    localparam int         FCTL_ODD1   = 1;
    localparam int         FCTL_ODD2   = 2;
    localparam int         FCTL_DEC1   = 4;
    localparam int         FCTL_DEC2   = 6;
    localparam logic [7:0] FCTL_MASK   = 8'hF7;
    localparam logic [7:0] FCTL_RST    = 8'h00;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int          DEC_W      = 17;
    localparam int          SHIFT_W    = 7;
    localparam int          DADDR_W    = 7;
    localparam int          CADDR_W    = 6;
    localparam logic [15:0] GAIN_RST   = 16'h4000;
    localparam logic [15:0] CHOP_RST   = 16'h0000;
    localparam logic [16:0] DEC_RST    = 17'h00008;
    localparam logic [6:0]  SHIFT_RST  = 7'h00;
    localparam logic [6:0]  DMIN_RST   = 7'h00;
    localparam logic [6:0]  DMAX_RST   = 7'h7F;
    localparam logic [5:0]  CMIN_RST   = 6'h00;
    localparam logic [5:0]  CMAX_RST   = 6'h3F;

    // ------------------------------------------------------------
    // Sampling rate
    // ------------------------------------------------------------
    localparam logic [4:0]  CYC_PER_CH = 5'h04;

endpackage

// >>> design/ccc_chopper.sv
`timescale 1ns/1ns
module ccc_chopper
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic [15:0] divider,
    input  wire logic        invert,
    input  wire logic        cal_phase,
    output logic             tick_q,
    output logic             wave_q
);

    // ------------------------------------------------------------
    // Period counter
    // ------------------------------------------------------------
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic        run;
    logic        last;
    logic        first_half;
    logic        wave_d;

    assign run        = (divider != 16'h0000);
    assign last       = (cnt_q >= divider - 16'h0001);
    assign cnt_d      = (!run || last) ? 16'h0000 : cnt_q + 16'h0001;
    assign first_half = (cnt_q < {1'b0, divider[15:1]});
    // Divider of one cannot make a square wave; only the tick runs then
    assign wave_d     = run & ((first_half ^ cal_phase) ^ invert);

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            cnt_q  <= 16'h0000;
            tick_q <= 1'b0;
            wave_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            tick_q <= run & last;
            wave_q <= wave_d;
        end
    end

endmodule

// >>> design/ccc_sample_tick.sv
`timescale 1ns/1ns
module ccc_sample_tick
(
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic [2:0] channels_in_use,
    output logic            tick_q
);

    // ------------------------------------------------------------
    // Sample period is four cycles per channel in use
    // ------------------------------------------------------------
    logic [4:0] period;
    logic [4:0] cnt_q;
    logic [2:0] chans;
    logic       last;

    // Zero channels would give a zero period, so it counts as one
    assign chans  = (channels_in_use == 3'h0) ? 3'h1 : channels_in_use;
    assign period = 5'(CYC_MUL(chans));
    assign last   = (cnt_q >= period - 5'h01);

    function automatic logic [4:0] CYC_MUL(input logic [2:0] n);
        CYC_MUL = 5'(ccc_pkg::CYC_PER_CH * n);
    endfunction

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            cnt_q  <= 5'h00;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= last ? 5'h00 : cnt_q + 5'h01;
            tick_q <= last;
        end
    end

endmodule

// >>> design/ccc_regs.sv
// What this block does
// - Cutoff select bit zero, reset 0.5MHz
// - Bit 1 inverts input through chopper
// - Bit 2 selects calibrated chopper phase
// - Bit 4 bypasses decimator, reset bypassed
// - Bit 5 enables FIR filter 0
// - Bit 6 enables FIR filter 1
// - Bit 7 bypasses FIR filter 0
// - Sixteen bit gain, two bytes, reset 4000h
// - Chopper divider zero disables chopper
// - Chopper runs at clock over divider
// - Seventeen bit decimation factor, reset 8
// - Sample rate is clock over 4N
// - Seven bit decimator shift, reset zero
// - Control bit 0 enables section f2
// - Control bits 1,2 select odd taps
// - Two bit decimation fields for f1, f2
// - Seven bit f1 data address window
// - Six bit f1 coefficient address window
// - Seven bit f2 data address window
// - Map repeats for channels 2 to 4
`timescale 1ns/1ns
module ccc_regs
(
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    input  wire logic [2:0]        channels_in_use,
    output logic      [3:0]        aaf_cutoff_3mhz,
    output logic      [3:0]        chopper_invert,
    output logic      [3:0]        chopper_cal_phase_sel,
    output logic      [3:0]        cic_bypass,
    output logic      [3:0]        filter0_enable,
    output logic      [3:0]        filter1_enable,
    output logic      [3:0]        filter0_bypass,
    output logic      [3:0][15:0]  recon_gain,
    output logic      [3:0][15:0]  chopper_divider,
    output logic      [3:0][16:0]  decimation_factor,
    output logic      [3:0][6:0]   decimator_shift,
    output logic      [3:0]        filter0_second_section_on,
    output logic      [3:0]        filter0_first_odd_taps,
    output logic      [3:0]        filter0_second_odd_taps,
    output logic      [3:0][1:0]   filter0_first_decim,
    output logic      [3:0][1:0]   filter0_second_decim,
    output logic      [3:0][6:0]   f1_data_min,
    output logic      [3:0][6:0]   f1_data_max,
    output logic      [3:0][5:0]   f1_coef_min,
    output logic      [3:0][5:0]   f1_coef_max,
    output logic      [3:0][6:0]   f2_data_min,
    output logic      [3:0][6:0]   f2_data_max,
    output logic      [3:0]        chopper_tick,
    output logic      [3:0]        chopper_wave,
    output logic                   sample_tick
);

    // ------------------------------------------------------------
    // Storage, one set per channel
    // ------------------------------------------------------------
    logic [3:0][7:0]  cfg_q;
    logic [3:0][15:0] gain_q;
    logic [3:0][15:0] chop_q;
    logic [3:0][16:0] dec_q;
    logic [3:0][6:0]  shift_q;
    logic [3:0][7:0]  fctl_q;
    logic [3:0][6:0]  f1dmin_q;
    logic [3:0][6:0]  f1dmax_q;
    logic [3:0][5:0]  f1cmin_q;
    logic [3:0][5:0]  f1cmax_q;
    logic [3:0][6:0]  f2dmin_q;
    logic [3:0][6:0]  f2dmax_q;

    logic [3:0][7:0]  loc;
    logic [3:0]       hit;
    logic [3:0][7:0]  rd_byte;
    logic [7:0]       rdata_d;

    // ------------------------------------------------------------
    // Per-channel decode, write and read select
    // ------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < ccc_pkg::CH_NUM; ch = ch + 1)
        begin : g_ch
            // Fold each channel onto channel 1 offsets
            assign loc[ch] = 8'(reg_addr - 8'(ch * ccc_pkg::CH_STRIDE));
            assign hit[ch] = (reg_addr >= 8'(ch * ccc_pkg::CH_STRIDE))
                             && (loc[ch] >= ccc_pkg::OFF_FIRST)
                             && (loc[ch] <= ccc_pkg::OFF_LAST);

            always_ff @(posedge core_clk)
            begin
                if (!nrst)
                begin
                    cfg_q[ch]    <= ccc_pkg::CFG_RST;
                    gain_q[ch]   <= ccc_pkg::GAIN_RST;
                    chop_q[ch]   <= ccc_pkg::CHOP_RST;
                    dec_q[ch]    <= ccc_pkg::DEC_RST;
                    shift_q[ch]  <= ccc_pkg::SHIFT_RST;
                    fctl_q[ch]   <= ccc_pkg::FCTL_RST;
                    f1dmin_q[ch] <= ccc_pkg::DMIN_RST;
                    f1dmax_q[ch] <= ccc_pkg::DMAX_RST;
                    f1cmin_q[ch] <= ccc_pkg::CMIN_RST;
                    f1cmax_q[ch] <= ccc_pkg::CMAX_RST;
                    f2dmin_q[ch] <= ccc_pkg::DMIN_RST;
                    f2dmax_q[ch] <= ccc_pkg::DMAX_RST;
                end
                else if (reg_wr && hit[ch])
                begin
                    case (loc[ch])
                        ccc_pkg::OFF_CFG:
                            cfg_q[ch] <= reg_wdata & ccc_pkg::CFG_MASK;
                        ccc_pkg::OFF_GAIN_LO:
                            gain_q[ch][7:0] <= reg_wdata;
                        ccc_pkg::OFF_GAIN_HI:
                            gain_q[ch][15:8] <= reg_wdata;
                        ccc_pkg::OFF_CHOP_LO:
                            chop_q[ch][7:0] <= reg_wdata;
                        ccc_pkg::OFF_CHOP_HI:
                            chop_q[ch][15:8] <= reg_wdata;
                        ccc_pkg::OFF_DEC_B0:
                            dec_q[ch][7:0] <= reg_wdata;
                        ccc_pkg::OFF_DEC_B1:
                            dec_q[ch][15:8] <= reg_wdata;
                        ccc_pkg::OFF_DEC_B2:
                            dec_q[ch][16] <= reg_wdata[0];
                        ccc_pkg::OFF_SHIFT:
                            shift_q[ch] <= reg_wdata[6:0];
                        ccc_pkg::OFF_FCTL:
                            fctl_q[ch] <= reg_wdata & ccc_pkg::FCTL_MASK;
                        ccc_pkg::OFF_F1DMIN:
                            f1dmin_q[ch] <= reg_wdata[6:0];
                        ccc_pkg::OFF_F1DMAX:
                            f1dmax_q[ch] <= reg_wdata[6:0];
                        ccc_pkg::OFF_F1CMIN:
                            f1cmin_q[ch] <= reg_wdata[5:0];
                        ccc_pkg::OFF_F1CMAX:
                            f1cmax_q[ch] <= reg_wdata[5:0];
                        ccc_pkg::OFF_F2DMIN:
                            f2dmin_q[ch] <= reg_wdata[6:0];
                        ccc_pkg::OFF_F2DMAX:
                            f2dmax_q[ch] <= reg_wdata[6:0];
                        default:
                            cfg_q[ch] <= cfg_q[ch];
                    endcase
                end
            end

            // Readback: unused positions come back as zero
            always_comb
            begin
                case (loc[ch])
                    ccc_pkg::OFF_CFG:     rd_byte[ch] = cfg_q[ch];
                    ccc_pkg::OFF_GAIN_LO: rd_byte[ch] = gain_q[ch][7:0];
                    ccc_pkg::OFF_GAIN_HI: rd_byte[ch] = gain_q[ch][15:8];
                    ccc_pkg::OFF_CHOP_LO: rd_byte[ch] = chop_q[ch][7:0];
                    ccc_pkg::OFF_CHOP_HI: rd_byte[ch] = chop_q[ch][15:8];
                    ccc_pkg::OFF_DEC_B0:  rd_byte[ch] = dec_q[ch][7:0];
                    ccc_pkg::OFF_DEC_B1:  rd_byte[ch] = dec_q[ch][15:8];
                    ccc_pkg::OFF_DEC_B2:  rd_byte[ch] = {7'h00, dec_q[ch][16]};
                    ccc_pkg::OFF_SHIFT:   rd_byte[ch] = {1'b0, shift_q[ch]};
                    ccc_pkg::OFF_FCTL:    rd_byte[ch] = fctl_q[ch];
                    ccc_pkg::OFF_F1DMIN:  rd_byte[ch] = {1'b0, f1dmin_q[ch]};
                    ccc_pkg::OFF_F1DMAX:  rd_byte[ch] = {1'b0, f1dmax_q[ch]};
                    ccc_pkg::OFF_F1CMIN:  rd_byte[ch] = {2'h0, f1cmin_q[ch]};
                    ccc_pkg::OFF_F1CMAX:  rd_byte[ch] = {2'h0, f1cmax_q[ch]};
                    ccc_pkg::OFF_F2DMIN:  rd_byte[ch] = {1'b0, f2dmin_q[ch]};
                    ccc_pkg::OFF_F2DMAX:  rd_byte[ch] = {1'b0, f2dmax_q[ch]};
                    default:              rd_byte[ch] = 8'h00;
                endcase
            end

            // --------------------------------------------------------
            // Settings straight from the storage flops
            // --------------------------------------------------------
            assign aaf_cutoff_3mhz[ch]       = cfg_q[ch][ccc_pkg::CFG_AAF];
            assign chopper_invert[ch]        = cfg_q[ch][ccc_pkg::CFG_INV];
            assign chopper_cal_phase_sel[ch] = cfg_q[ch][ccc_pkg::CFG_CALPH];
            assign cic_bypass[ch]            = cfg_q[ch][ccc_pkg::CFG_CICBYP];
            assign filter0_enable[ch]        = cfg_q[ch][ccc_pkg::CFG_F0EN];
            assign filter1_enable[ch]        = cfg_q[ch][ccc_pkg::CFG_F1EN];
            assign filter0_bypass[ch]        = cfg_q[ch][ccc_pkg::CFG_F0BYP];
            assign filter0_second_section_on[ch] = fctl_q[ch][ccc_pkg::FCTL_F2EN];
            assign filter0_first_odd_taps[ch]    = fctl_q[ch][ccc_pkg::FCTL_ODD1];
            assign filter0_second_odd_taps[ch]   = fctl_q[ch][ccc_pkg::FCTL_ODD2];
            assign filter0_first_decim[ch]  = fctl_q[ch][ccc_pkg::FCTL_DEC1 +: 2];
            assign filter0_second_decim[ch] = fctl_q[ch][ccc_pkg::FCTL_DEC2 +: 2];

            // --------------------------------------------------------
            // Chopper rate generator
            // --------------------------------------------------------
            ccc_chopper u_chop
            (
                .core_clk  (core_clk),
                .nrst      (nrst),
                .divider   (chop_q[ch]),
                .invert    (cfg_q[ch][ccc_pkg::CFG_INV]),
                .cal_phase (cfg_q[ch][ccc_pkg::CFG_CALPH]),
                .tick_q    (chopper_tick[ch]),
                .wave_q    (chopper_wave[ch])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Wide fields out
    // ------------------------------------------------------------
    assign recon_gain        = gain_q;
    assign chopper_divider   = chop_q;
    assign decimation_factor = dec_q;
    assign decimator_shift   = shift_q;
    assign f1_data_min       = f1dmin_q;
    assign f1_data_max       = f1dmax_q;
    assign f1_coef_min       = f1cmin_q;
    assign f1_coef_max       = f1cmax_q;
    assign f2_data_min       = f2dmin_q;
    assign f2_data_max       = f2dmax_q;

    // ------------------------------------------------------------
    // Read data; unmapped addresses answer zero
    // ------------------------------------------------------------
    assign rdata_d = (hit[0] ? rd_byte[0] : 8'h00)
                   | (hit[1] ? rd_byte[1] : 8'h00)
                   | (hit[2] ? rd_byte[2] : 8'h00)
                   | (hit[3] ? rd_byte[3] : 8'h00);

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rdata_d;
    end

    // ------------------------------------------------------------
    // Channel sample strobe
    // ------------------------------------------------------------
    ccc_sample_tick u_sample
    (
        .core_clk        (core_clk),
        .nrst            (nrst),
        .channels_in_use (channels_in_use),
        .tick_q          (sample_tick)
    );

endmodule

// >>> sim/ccc_regs_props.sv
`timescale 1ns/1ns
module ccc_regs_props
(
    input wire logic             core_clk,
    input wire logic             nrst,
    input wire logic [7:0]       reg_addr,
    input wire logic [7:0]       reg_wdata,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [7:0]       reg_rdata,
    input wire logic [2:0]       channels_in_use,
    input wire logic [3:0]       aaf_cutoff_3mhz,
    input wire logic [3:0]       cic_bypass,
    input wire logic [3:0][15:0] recon_gain,
    input wire logic [3:0][15:0] chopper_divider,
    input wire logic [3:0][6:0]  decimator_shift,
    input wire logic [3:0]       chopper_tick,
    input wire logic [3:0]       chopper_wave,
    input wire logic             sample_tick
);
    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    chk_reset_values: assert property ($rose(nrst) |-> recon_gain[0] == 16'h4000
        && chopper_divider[0] == 16'h0000) else $error("settings not at reset values");
    chk_gain_low: assert property (reg_wr && reg_addr == 8'h33
        |=> recon_gain[0][7:0] == $past(reg_wdata)) else $error("gain low byte not written");
    chk_read_mirror: assert property (reg_rd && reg_addr == 8'h64
        |=> reg_rdata == $past(recon_gain[1][15:8])) else $error("channel 2 gain read wrong");
    chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    chk_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h32 || reg_addr > 8'hF1)
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    chk_cfg_fields: assert property (reg_wr && reg_addr == 8'h92
        |=> aaf_cutoff_3mhz[2] == $past(reg_wdata[0]) && cic_bypass[2] == $past(reg_wdata[4]))
        else $error("channel 3 configuration not written");
    chk_shift_ch4: assert property (reg_wr && reg_addr == 8'hCA
        |=> decimator_shift[3] == $past(reg_wdata[6:0])) else $error("channel 4 shift wrong");
    chk_chop_off: assert property ((chopper_divider[0] == 16'h0000) [*2]
        |-> chopper_tick[0] == 1'b0 && chopper_wave[0] == 1'b0) else $error("chopper not off");
    chk_chop_period: assert property (chopper_tick[0] && chopper_divider[0] == 16'h0005
        |=> (chopper_tick[0] == 1'b0) [*4] ##1 chopper_tick[0]) else $error("chopper period");
    chk_sample_gap: assert property (sample_tick && channels_in_use == 3'h2
        |=> (!sample_tick) [*7] ##1 sample_tick) else $error("sample tick period");
endmodule
bind ccc_regs ccc_regs_props u_props (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .channels_in_use, .aaf_cutoff_3mhz, .cic_bypass, .recon_gain,
    .chopper_divider, .decimator_shift, .chopper_tick, .chopper_wave, .sample_tick);

// >>> sim/channel_chain_config_regs_tb_top.sv
`timescale 1ns/1ns
module channel_chain_config_regs_tb_top;
    // ------------------------------------------------------------
    // Signals and byte model
    // ------------------------------------------------------------
    logic              core_clk = 1'b0;
    logic              nrst = 1'b0;
    logic [7:0]        reg_addr = 8'h00;
    logic [7:0]        reg_wdata = 8'h00;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [7:0]        reg_rdata;
    logic [2:0]        channels_in_use = 3'h2;
    logic [3:0]        aaf_cutoff_3mhz, chopper_invert, chopper_cal_phase_sel, cic_bypass;
    logic [3:0]        filter0_enable, filter1_enable, filter0_bypass, chopper_tick, chopper_wave;
    logic [3:0]        filter0_second_section_on, filter0_first_odd_taps, filter0_second_odd_taps;
    logic [3:0][15:0]  recon_gain, chopper_divider;
    logic [3:0][16:0]  decimation_factor;
    logic [3:0][6:0]   decimator_shift, f1_data_min, f1_data_max, f2_data_min, f2_data_max;
    logic [3:0][5:0]   f1_coef_min, f1_coef_max;
    logic [3:0][1:0]   filter0_first_decim, filter0_second_decim;
    logic              sample_tick;
    logic [7:0]        m [256];
    logic [7:0]        exp_rd, pw_a, pw_d, ra;
    logic              pend_rd = 1'b0;
    logic              pend_wr = 1'b0;
    int                err_count = 0, n_checks = 0, cycles = 0, nt, nw, nt1, ns;
    localparam logic [7:0] MSK [16] = '{8'hF7, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01,
        8'h7F, 8'hF7, 8'h7F, 8'h7F, 8'h3F, 8'h3F, 8'h7F, 8'h7F};
    localparam logic [7:0] RST [16] = '{8'hF0, 8'h00, 8'h40, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h7F, 8'h00, 8'h3F, 8'h00, 8'h7F};
    localparam logic [7:0] CFGV [4] = '{8'hF0, 8'hF2, 8'hF6, 8'hF4};
    localparam int         WAVE [4] = '{4, 6, 4, 6};

    ccc_regs DUT (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .channels_in_use, .aaf_cutoff_3mhz, .chopper_invert, .chopper_cal_phase_sel, .cic_bypass,
        .filter0_enable, .filter1_enable, .filter0_bypass, .recon_gain, .chopper_divider,
        .decimation_factor, .decimator_shift, .filter0_second_section_on, .filter0_first_odd_taps,
        .filter0_second_odd_taps, .filter0_first_decim, .filter0_second_decim, .f1_data_min,
        .f1_data_max, .f1_coef_min, .f1_coef_max, .f2_data_min, .f2_data_max, .chopper_tick,
        .chopper_wave, .sample_tick);

    always #10 core_clk = ~core_clk;

    // Whole run is about 3600 cycles; the ceiling leaves ample slack
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 12000)
        begin
            err_count++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic int offs(input int a);
        if (a < 8'h32 || a > 8'hF1 || (a - 8'h32) % 8'h30 > 15)
            return -1;
        return (a - 8'h32) % 8'h30;
    endfunction

    function automatic logic [127:0] expv(input int k);
        int b;
        b = 8'h32 + 8'h30 * k;
        return 128'({m[b][7:4], m[b][2:0], m[b+2], m[b+1], m[b+4], m[b+3], m[b+7][0], m[b+6],
            m[b+5], m[b+8][6:0], m[b+9][7:4], m[b+9][2:0], m[b+10][6:0], m[b+11][6:0],
            m[b+12][5:0], m[b+13][5:0], m[b+14][6:0], m[b+15][6:0]});
    endfunction

    function automatic logic [127:0] outs(input int k);
        return 128'({filter0_bypass[k], filter1_enable[k], filter0_enable[k], cic_bypass[k],
            chopper_cal_phase_sel[k], chopper_invert[k], aaf_cutoff_3mhz[k], recon_gain[k],
            chopper_divider[k], decimation_factor[k], decimator_shift[k], filter0_second_decim[k],
            filter0_first_decim[k], filter0_second_odd_taps[k], filter0_first_odd_taps[k],
            filter0_second_section_on[k], f1_data_min[k], f1_data_max[k], f1_coef_min[k],
            f1_coef_max[k], f2_data_min[k], f2_data_max[k]});
    endfunction

    task automatic check(input logic [127:0] seen, input logic [127:0] expd);
        n_checks++;
        if (seen !== expd)
        begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask

    // One bus cycle; the previous call's request is taken at this rising edge
    // and judged at the falling edge after it, once the flops have settled
    task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        int o;
        @(posedge core_clk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(negedge core_clk);
        if (pend_rd)
            check(128'(reg_rdata), 128'(exp_rd));
        if (pend_wr && offs(pw_a) >= 0)
            m[pw_a] = pw_d & MSK[offs(pw_a)];
        for (int k = 0; k < 4; k++)
            check(outs(k), expv(k));
        // Channels 3 and 4 never get a divider, so their chopper stays quiet
        check(128'({chopper_tick[3:2], chopper_wave[3:2]}), 128'(0));
        nt += chopper_tick[0];
        nw += chopper_wave[0];
        nt1 += chopper_tick[1];
        ns += sample_tick;
        pend_wr = w;
        pend_rd = r;
        pw_a = a;
        pw_d = d;
        o = offs(a);
        exp_rd = (o >= 0) ? m[a] : 8'h00;
    endtask

    task automatic do_reset(input logic [2:0] n);
        @(posedge core_clk);
        nrst <= 1'b0;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        channels_in_use <= n;
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        for (int a = 0; a < 256; a++)
            m[a] = (offs(a) >= 0) ? RST[offs(a)] : 8'h00;
        pend_wr = 1'b0;
        pend_rd = 1'b1;
        exp_rd = 8'h00;
    endtask

    task automatic read_map(input string name);
        for (int a = 0; a < 256; a++)
            cyc(1'b0, 1'b1, a[7:0], 8'h00);
        $display("test %s done", name);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'hA527B38C));
        do_reset(3'h2);
        read_map("reset_map");
        // Divider bytes stay out of the traffic so the chopper counter never runs long
        for (int i = 0; i < 3000; i++)
        begin
            ra = 8'($urandom_range(8'h28, 8'hF8));
            cyc(1'($urandom) && offs(ra) != 3 && offs(ra) != 4, 1'($urandom), ra, 8'($urandom));
        end
        $display("test random_traffic done");
        cyc(1'b0, 1'b0, 8'h00, 8'h00);
        do_reset(3'h3);
        read_map("second_reset");
        ns = 0;
        repeat (24) cyc(1'b0, 1'b0, 8'h00, 8'h00);
        check(128'(ns), 128'(2));
        cyc(1'b1, 1'b0, 8'h35, 8'h05);
        cyc(1'b1, 1'b0, 8'h65, 8'h01);
        // Filter control goes in as one whole preset byte, never bit by bit
        cyc(1'b1, 1'b0, 8'h3B, 8'h51);
        for (int i = 0; i < 4; i++)
        begin
            cyc(1'b1, 1'b0, 8'h32, CFGV[i]);
            repeat (6) cyc(1'b0, 1'b0, 8'h00, 8'h00);
            nt = 0;
            nw = 0;
            nt1 = 0;
            repeat (10) cyc(1'b0, 1'b0, 8'h00, 8'h00);
            check(128'(nt), 128'(2));
            check(128'(nw), 128'(WAVE[i]));
            check(128'(nt1), 128'(10));
        end
        $display("test chopper done");
        summarize();
    end
endmodule
